// File: design/lvt_video_timing.sv
// Purpose: lcd panel timing, frame buffer address counters, colour tables, dither pattern store
// Assumes: sys_clk 250 MHz, inputs synchronous, axi4-lite register access
// Notes: register bodies other than control and status are write-only and read back as zero
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module lvt_video_timing (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fetch_advance,
  input wire logic [7:0] pixel_code,
  output logic shift_clock,
  output logic line_load,
  output logic frame,
  output logic ac_drive_toggle,
  output logic line_done_sync,
  output logic [31:0] fetch_addr_upper,
  output logic [31:0] fetch_addr_lower,
  output logic [8:0] horizontal_size_field,
  output logic [3:0] red_shade,
  output logic [3:0] green_shade,
  output logic [3:0] blue_shade,
  output logic [3:0] pat_two_of_three,
  output logic [3:0] pat_one_of_three,
  output logic [3:0] pat_three_of_four,
  output logic [3:0] pat_two_of_four,
  output logic [3:0] pat_four_of_five,
  output logic [3:0] pat_one_of_five,
  output logic [2:0] line_phase_mod7
);
  import lvt_pkg::*;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [11:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic [31:0] ctrl_reg;
  logic [31:0] timing_reg;
  logic [31:0] bank_upper_reg;
  logic [31:0] toggle_lower_reg;
  logic [31:0] red_reg;
  logic [31:0] green_reg;
  logic [31:0] blue_reg;
  logic [31:0] pat3_reg;
  logic [31:0] pat4_reg;
  logic [31:0] pat5_reg;
  logic [9:0] line_cnt_reg;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_have_reg <= 1'b0;
      w_data_reg <= RESET_VALUE;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        case (aw_addr_reg)
          OFF_CTRL, OFF_LINE_TIMING, OFF_BANK_UPPER, OFF_TOGGLE_LOWER, OFF_RED, OFF_GREEN,
          OFF_BLUE, OFF_PAT3, OFF_PAT4, OFF_PAT5: bresp_reg <= RESP_OKAY;
          default: bresp_reg <= RESP_SLVERR;
        endcase
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // reserved bits are masked off before storing
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= RESET_VALUE;
      timing_reg <= RESET_VALUE;
      bank_upper_reg <= RESET_VALUE;
      toggle_lower_reg <= RESET_VALUE;
      red_reg <= RESET_VALUE;
      green_reg <= RESET_VALUE;
      blue_reg <= RESET_VALUE;
      pat3_reg <= RESET_VALUE;
      pat4_reg <= RESET_VALUE;
      pat5_reg <= RESET_VALUE;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        OFF_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg, MASK_CTRL);
        OFF_LINE_TIMING: timing_reg <= merge(timing_reg, w_data_reg, w_strb_reg, MASK_LINE_TIMING);
        OFF_BANK_UPPER: bank_upper_reg <= merge(bank_upper_reg, w_data_reg, w_strb_reg, MASK_BANK_UPPER);
        OFF_TOGGLE_LOWER: toggle_lower_reg <= merge(toggle_lower_reg, w_data_reg, w_strb_reg, MASK_TOGGLE_LOWER);
        OFF_RED: red_reg <= merge(red_reg, w_data_reg, w_strb_reg, 32'hffff_ffff);
        OFF_GREEN: green_reg <= merge(green_reg, w_data_reg, w_strb_reg, 32'hffff_ffff);
        OFF_BLUE: blue_reg <= merge(blue_reg, w_data_reg, w_strb_reg, MASK_BLUE);
        OFF_PAT3: pat3_reg <= merge(pat3_reg, w_data_reg, w_strb_reg, MASK_PAT3);
        OFF_PAT4: pat4_reg <= merge(pat4_reg, w_data_reg, w_strb_reg, 32'hffff_ffff);
        OFF_PAT5: pat5_reg <= merge(pat5_reg, w_data_reg, w_strb_reg, MASK_PAT5);
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // table registers are write-only; only control and status read back
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= RESET_VALUE;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= RESET_VALUE;
      rresp_reg <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: rdata_reg <= ctrl_reg;
        OFF_STATUS: rdata_reg <= {20'h00000, ac_drive_toggle, frame, line_cnt_reg};
        OFF_LINE_TIMING, OFF_BANK_UPPER, OFF_TOGGLE_LOWER, OFF_RED, OFF_GREEN,
        OFF_BLUE, OFF_PAT3, OFF_PAT4, OFF_PAT5: rdata_reg <= RESET_VALUE;
        default: rresp_reg <= RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  logic enable;
  logic toggle_mode;
  logic [1:0] colour_mode;
  logic [4:0] shift_div;
  logic [9:0] line_div;
  logic [9:0] line_count;
  logic [7:0] toggle_div;
  logic [3:0] sync_mask;
  assign enable = ctrl_reg[CTRL_ENABLE_BIT];
  assign toggle_mode = ctrl_reg[CTRL_TOGGLE_MODE_BIT];
  assign colour_mode = ctrl_reg[CTRL_COLOUR_MODE_LSB +: 2];
  assign shift_div = ctrl_reg[CTRL_SHIFT_DIV_LSB +: 5];
  assign line_div = timing_reg[LINE_DIV_LSB +: 10];
  assign line_count = timing_reg[LINE_COUNT_LSB +: 10];
  assign toggle_div = toggle_lower_reg[TOGGLE_DIV_LSB +: 8];
  assign sync_mask = toggle_lower_reg[SYNC_MASK_LSB +: 4];
  assign horizontal_size_field = timing_reg[HSIZE_LSB +: 9];

  // ----------------------------------------------------------------
  // line and frame timing
  // ----------------------------------------------------------------
  logic [4:0] half_cnt_reg;
  logic shift_clock_reg;
  logic period_end;
  logic [9:0] shift_cnt_reg;
  logic load_next;
  logic load_reg;
  logic frame_start;
  logic frame_reg;
  logic [3:0] mask_cnt_reg;
  logic done_reg;
  logic [7:0] toggle_cnt_reg;
  logic ac_reg;

  // one shift clock period is 2*(divider+1) sys_clk cycles
  assign period_end = enable && shift_clock_reg && half_cnt_reg == shift_div;
  assign load_next = period_end && shift_cnt_reg == line_div;
  assign frame_start = load_next && line_cnt_reg == line_count;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      half_cnt_reg <= 5'h00;
      shift_clock_reg <= 1'b0;
    end else if (!enable) begin
      half_cnt_reg <= 5'h00;
      shift_clock_reg <= 1'b0;
    end else if (half_cnt_reg == shift_div) begin
      half_cnt_reg <= 5'h00;
      shift_clock_reg <= !shift_clock_reg;
    end else begin
      half_cnt_reg <= half_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shift_cnt_reg <= 10'h000;
      line_cnt_reg <= 10'h000;
      load_reg <= 1'b0;
      frame_reg <= 1'b0;
    end else if (!enable) begin
      shift_cnt_reg <= 10'h000;
      line_cnt_reg <= 10'h000;
      load_reg <= 1'b0;
      frame_reg <= 1'b0;
    end else begin
      load_reg <= load_next;
      // frame is a one-cycle pulse beside the load that opens the frame
      frame_reg <= frame_start;
      if (load_next) begin
        shift_cnt_reg <= 10'h000;
        line_cnt_reg <= frame_start ? 10'h000 : line_cnt_reg + 10'h001;
      end else if (period_end) begin
        shift_cnt_reg <= shift_cnt_reg + 10'h001;
      end
    end
  end

  // the mask holds the sync pulse off for sync_mask line loads after each frame start
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_cnt_reg <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (frame_start) begin
        mask_cnt_reg <= sync_mask;
        // the last line of a frame raises done only once the mask count has run down to zero
        done_reg <= mask_cnt_reg == 4'h0;
      end else if (load_next && mask_cnt_reg != 4'h0) begin
        mask_cnt_reg <= mask_cnt_reg - 4'h1;
      end else if (load_next) begin
        done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      toggle_cnt_reg <= 8'h00;
      ac_reg <= 1'b0;
    end else if (toggle_mode) begin
      if (load_next && toggle_cnt_reg == toggle_div) begin
        toggle_cnt_reg <= 8'h00;
        ac_reg <= !ac_reg;
      end else if (load_next) begin
        toggle_cnt_reg <= toggle_cnt_reg + 8'h01;
      end
    end else begin
      toggle_cnt_reg <= 8'h00;
      if (frame_start) begin
        ac_reg <= !ac_reg;
      end
    end
  end

  assign shift_clock = shift_clock_reg;
  assign line_load = load_reg;
  assign frame = frame_reg;
  assign line_done_sync = done_reg;
  assign ac_drive_toggle = ac_reg;

  // ----------------------------------------------------------------
  // frame buffer address counters
  // ----------------------------------------------------------------
  logic [11:0] bank_reg;
  logic [15:0] upper_cnt_reg;
  logic [15:0] lower_cnt_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bank_reg <= 12'h000;
      upper_cnt_reg <= 16'h0000;
      lower_cnt_reg <= 16'h0000;
    end else if (frame_start) begin
      bank_reg <= bank_upper_reg[BANK_LSB +: 12];
      upper_cnt_reg <= bank_upper_reg[BASE_LSB +: 16];
      lower_cnt_reg <= toggle_lower_reg[BASE_LSB +: 16];
    end else if (fetch_advance) begin
      upper_cnt_reg <= upper_cnt_reg + 16'h0001;
      lower_cnt_reg <= lower_cnt_reg + 16'h0001;
    end
  end

  assign fetch_addr_upper = {bank_reg, upper_cnt_reg, 4'h0};
  assign fetch_addr_lower = {bank_reg, lower_cnt_reg, 4'h0};

  // ----------------------------------------------------------------
  // colour expansion
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      red_shade <= 4'h0;
      green_shade <= 4'h0;
      blue_shade <= 4'h0;
    end else begin
      red_shade <= 4'h0;
      green_shade <= 4'h0;
      blue_shade <= pixel_code[3:0];
      case (colour_mode)
        MODE_COLOUR8: begin
          red_shade <= red_reg[pixel_code[7:5]*4 +: 4];
          green_shade <= green_reg[pixel_code[4:2]*4 +: 4];
          blue_shade <= blue_reg[pixel_code[1:0]*4 +: 4];
        end
        MODE_GREY2: blue_shade <= blue_reg[pixel_code[1:0]*4 +: 4];
        MODE_MONO: blue_shade <= {4{pixel_code[0]}};
        default: blue_shade <= pixel_code[3:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // dither line counters and pattern select
  // ----------------------------------------------------------------
  logic [1:0] ph3_reg;
  logic [1:0] ph4_reg;
  logic [2:0] ph5_reg;
  logic [2:0] ph7_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ph3_reg <= 2'h0;
      ph4_reg <= 2'h0;
      ph5_reg <= 3'h0;
      ph7_reg <= 3'h0;
    end else if (load_next) begin
      ph3_reg <= (ph3_reg == 2'h2) ? 2'h0 : ph3_reg + 2'h1;
      ph4_reg <= ph4_reg + 2'h1;
      ph5_reg <= (ph5_reg == 3'h4) ? 3'h0 : ph5_reg + 3'h1;
      ph7_reg <= (ph7_reg == 3'h6) ? 3'h0 : ph7_reg + 3'h1;
    end
  end

  // line 0 always takes the most significant nibble of each field
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pat_two_of_three <= 4'h0;
      pat_one_of_three <= 4'h0;
      pat_three_of_four <= 4'h0;
      pat_two_of_four <= 4'h0;
      pat_four_of_five <= 4'h0;
      pat_one_of_five <= 4'h0;
    end else begin
      pat_two_of_three <= pat3_reg[(2'd2 - ph3_reg)*4 +: 4];
      pat_one_of_three <= ~pat3_reg[(2'd2 - ph3_reg)*4 +: 4];
      pat_three_of_four <= pat4_reg[PAT_THREE_OF_FOUR_LSB + (2'd3 - ph4_reg)*4 +: 4];
      pat_two_of_four <= pat4_reg[(2'd3 - ph4_reg)*4 +: 4];
      pat_four_of_five <= pat5_reg[(3'd4 - ph5_reg)*4 +: 4];
      pat_one_of_five <= ~pat5_reg[(3'd4 - ph5_reg)*4 +: 4];
    end
  end

  assign line_phase_mod7 = ph7_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_load_count: assert property (@(posedge sys_clk) disable iff (reset)
    line_load |-> $past(shift_cnt_reg) == $past(line_div))
    else $error("line load without full shift count");
  a_frame_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    frame |-> line_cnt_reg == 10'h000 && $past(line_cnt_reg) == $past(line_count))
    else $error("frame not at line count wrap");
  a_bank_latch: assert property (@(posedge sys_clk) disable iff (reset)
    !frame_start ##1 !$past(frame_start) |-> $stable(fetch_addr_upper[31:20]))
    else $error("bank changed inside a frame");
  a_upper_restart: assert property (@(posedge sys_clk) disable iff (reset)
    frame_start |=> upper_cnt_reg == $past(bank_upper_reg[19:4]))
    else $error("upper counter not restarted");
  a_sync_masked: assert property (@(posedge sys_clk) disable iff (reset)
    frame_start |=> mask_cnt_reg == $past(sync_mask) && line_done_sync == ($past(mask_cnt_reg) == 4'h0))
    else $error("sync mask not loaded");
  a_sync_after_line: assert property (@(posedge sys_clk) disable iff (reset)
    line_done_sync |-> $past(load_next) && $past(mask_cnt_reg) == 4'h0)
    else $error("line done while masked");
  a_frame_toggle: assert property (@(posedge sys_clk) disable iff (reset)
    !toggle_mode && $past(!toggle_mode) && $past(frame_start) |-> ac_drive_toggle != $past(ac_drive_toggle))
    else $error("drive not toggled per frame");
  a_div_toggle: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(ac_drive_toggle) && $past(toggle_mode) |-> $past(toggle_cnt_reg) == $past(toggle_div))
    else $error("drive toggled at wrong line");
  a_red_lookup: assert property (@(posedge sys_clk) disable iff (reset)
    colour_mode == MODE_COLOUR8 && pixel_code[7:5] == 3'h7 ##1 $stable(red_reg)
    |-> red_shade == red_reg[31:28])
    else $error("red code seven wrong nibble");
  a_pattern_line0: assert property (@(posedge sys_clk) disable iff (reset)
    ph3_reg == 2'h0 ##1 $stable(pat3_reg) |-> pat_two_of_three == pat3_reg[11:8]
    && pat_one_of_three == ~pat3_reg[11:8])
    else $error("line zero pattern wrong");
  a_ro_zero: assert property (@(posedge sys_clk) disable iff (reset)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_RED |=> s_axi_rdata == 32'h0000_0000)
    else $error("write-only register read nonzero");
  c_frame: cover property (@(posedge sys_clk) disable iff (reset) frame);
  c_sync: cover property (@(posedge sys_clk) disable iff (reset) line_done_sync);
  c_drive: cover property (@(posedge sys_clk) disable iff (reset) toggle_mode && $changed(ac_drive_toggle));
endmodule : lvt_video_timing

// File: pkg/lvt_pkg.sv
// Purpose: constants for the lcd video timing and dither configuration block
// Assumes: 32-bit axi4-lite register access, byte addresses as printed
// Notes: all registers in the documented range except control and status are write-only
package lvt_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_LINE_TIMING = 12'h02c;
  localparam logic [11:0] OFF_BANK_UPPER = 12'h030;
  localparam logic [11:0] OFF_TOGGLE_LOWER = 12'h034;
  localparam logic [11:0] OFF_RED = 12'h038;
  localparam logic [11:0] OFF_GREEN = 12'h03c;
  localparam logic [11:0] OFF_BLUE = 12'h040;
  localparam logic [11:0] OFF_PAT3 = 12'h044;
  localparam logic [11:0] OFF_PAT4 = 12'h048;
  localparam logic [11:0] OFF_PAT5 = 12'h04c;
  // ----------------------------------------------------------------
  // writable bit masks, reserved bits never stored
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_CTRL = 32'h001f_003d;
  localparam logic [31:0] MASK_LINE_TIMING = 32'hffdf_f3ff;
  localparam logic [31:0] MASK_BANK_UPPER = 32'hffff_fff0;
  localparam logic [31:0] MASK_TOGGLE_LOWER = 32'hffff_fff0;
  localparam logic [31:0] MASK_BLUE = 32'h0000_ffff;
  localparam logic [31:0] MASK_PAT3 = 32'h0000_0fff;
  localparam logic [31:0] MASK_PAT5 = 32'h000f_ffff;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TOGGLE_MODE_BIT = 3;
  localparam int CTRL_COLOUR_MODE_LSB = 4;
  localparam int CTRL_SHIFT_DIV_LSB = 16;
  localparam int LINE_DIV_LSB = 22;
  localparam int HSIZE_LSB = 12;
  localparam int LINE_COUNT_LSB = 0;
  localparam int BANK_LSB = 20;
  localparam int BASE_LSB = 4;
  localparam int TOGGLE_DIV_LSB = 24;
  localparam int SYNC_MASK_LSB = 20;
  localparam int PAT_THREE_OF_FOUR_LSB = 16;
  // ----------------------------------------------------------------
  // colour modes and bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_MONO = 2'h0;
  localparam logic [1:0] MODE_GREY2 = 2'h1;
  localparam logic [1:0] MODE_GREY4 = 2'h2;
  localparam logic [1:0] MODE_COLOUR8 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lvt_pkg

// File: dv/lvt_panel_model.sv
// Purpose: passive panel model counting shift edges, lines and drive toggles
// Assumes: frame coincides with a line load
// Notes: panel only listens, it drives nothing back
`timescale 1ns/1ns
module lvt_panel_model (
  input wire logic sys_clk,
  input wire logic shift_clock,
  input wire logic line_load,
  input wire logic frame,
  input wire logic ac_drive_toggle,
  output int shifts_per_line,
  output int lines_per_frame,
  output int lines_per_toggle
);
  // --------------------------------------------------
  // counters
  // --------------------------------------------------
  logic sc_q, ac_q;
  int s_cnt, l_cnt, t_cnt;
  always_ff @(posedge sys_clk) begin
    sc_q <= shift_clock;
    ac_q <= ac_drive_toggle;
    // an edge that meets the load counts once either way
    if (line_load) begin
      shifts_per_line <= s_cnt + int'(shift_clock && !sc_q);
      s_cnt <= 0;
    end else if (shift_clock && !sc_q) begin
      s_cnt <= s_cnt + 1;
    end
    if (frame) begin
      lines_per_frame <= l_cnt;
      l_cnt <= 1;
    end else if (line_load) begin
      l_cnt <= l_cnt + 1;
    end
    if (ac_drive_toggle != ac_q) begin
      lines_per_toggle <= t_cnt + int'(line_load);
      t_cnt <= 0;
    end else if (line_load) begin
      t_cnt <= t_cnt + 1;
    end
  end
endmodule : lvt_panel_model

// File: dv/lcd_video_timing_dither_config_tb_top.sv
// Purpose: register-driven checks of line timing, tables and frame latching
// Assumes: every port of the design has a same-named signal here
// Notes: fetch_advance pulses once, after the bank change, to step both counters
`timescale 1ns/1ns
module lcd_video_timing_dither_config_tb_top;
  import lvt_pkg::*;
  // --------------------------------------------------
  // signals
  // --------------------------------------------------
  logic sys_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fetch_advance;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic shift_clock, line_load, frame, ac_drive_toggle, line_done_sync;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, fetch_addr_upper, fetch_addr_lower;
  logic [3:0] s_axi_wstrb, red_shade, green_shade, blue_shade, pat_two_of_three, pat_one_of_three;
  logic [3:0] pat_three_of_four, pat_two_of_four, pat_four_of_five, pat_one_of_five;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pixel_code;
  logic [8:0] horizontal_size_field;
  logic [2:0] line_phase_mod7;
  int fail_count, samples_checked, shifts_per_line, lines_per_frame, lines_per_toggle, lines_seen;
  localparam logic [31:0] P3 = 32'h0000_07da, P4 = 32'h7dbe_a5a5, P5 = 32'h0007_dfbe;
  // line loads since reset give every dither phase
  always @(posedge sys_clk)
    if (line_load) lines_seen <= lines_seen + 1;
  lvt_video_timing lvt_video_timing_i (.*);
  lvt_panel_model lvt_panel_model_i (.*);
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------
  // tasks
  // --------------------------------------------------
  task complete_run;
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task bump(inout int n);
    n++;
    if (n > 2000) begin
      fail_count++;
      complete_run;
    end
  endtask : bump
  task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      bump(n);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, RESP_OKAY);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      bump(n);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, d);
    chk("rresp", s_axi_rresp, r);
  endtask : rd
  task wf;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      bump(n);
    end while (!frame);
    repeat (3) @(posedge sys_clk);
  endtask : wf
  // --------------------------------------------------
  // sequence
  // --------------------------------------------------
  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fetch_advance} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    pixel_code = '0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    wr(OFF_RED, 32'hfedc_ba98);
    wr(OFF_GREEN, 32'h0123_4567);
    wr(OFF_BLUE, 32'h0000_9630);
    wr(OFF_LINE_TIMING, 32'h0084_f002);
    wr(OFF_BANK_UPPER, 32'habc1_2340);
    wr(OFF_TOGGLE_LOWER, 32'h0105_6780);
    wr(OFF_PAT3, P3);
    wr(OFF_PAT4, P4);
    wr(OFF_PAT5, P5);
    chk("hsize", horizontal_size_field, 32'h0000_004f);
    // every colour mode in turn; enable, toggle mode, shift divider one
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 32'h0001_0009 | 32'(m << 4));
      for (int n = 0; n < 8; n++) begin
        @(posedge sys_clk);
        pixel_code <= {n[2:0], n[2:0], n[1:0]};
        @(posedge sys_clk);
        #1;
        chk("blue", blue_shade, m == 0 ? {4{n[0]}} : m == 2 ? {n[1:0], n[1:0]} : 3 * n[1:0]);
        chk("red", red_shade, m == 3 ? 8 + n : 0);
        chk("green", green_shade, m == 3 ? 7 - n : 0);
      end
    end
    wf;
    wf;
    chk("shifts", shifts_per_line, 3);
    chk("lines", lines_per_frame, 3);
    chk("upper", fetch_addr_upper, 32'habc1_2340);
    chk("lower", fetch_addr_lower, 32'habc5_6780);
    chk("toggle", lines_per_toggle, 2);
    // seven lines in a row walk every phase of the line counters
    for (int k = 0; k < 7; k++) begin
      int w;
      w = 0;
      do begin
        @(posedge sys_clk);
        bump(w);
      end while (!line_load);
      chk("done", line_done_sync, 1'b1);
      @(posedge sys_clk);
      #1;
      chk("p23", pat_two_of_three, (P3 >> (4 * (2 - lines_seen % 3))) & 32'hf);
      chk("p13", pat_one_of_three, ~(P3 >> (4 * (2 - lines_seen % 3))) & 32'hf);
      chk("p34", pat_three_of_four, (P4 >> (16 + 4 * (3 - lines_seen % 4))) & 32'hf);
      chk("p24", pat_two_of_four, (P4 >> (4 * (3 - lines_seen % 4))) & 32'hf);
      chk("p45", pat_four_of_five, (P5 >> (4 * (4 - lines_seen % 5))) & 32'hf);
      chk("p15", pat_one_of_five, ~(P5 >> (4 * (4 - lines_seen % 5))) & 32'hf);
      chk("ph7", line_phase_mod7, lines_seen % 7);
    end
    wr(OFF_BANK_UPPER, 32'h1231_2340);
    chk("bank hold", fetch_addr_upper, 32'habc1_2340);
    wf;
    chk("bank new", fetch_addr_upper, 32'h1231_2340);
    @(posedge sys_clk);
    fetch_advance <= 1'b1;
    @(posedge sys_clk);
    fetch_advance <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("upper step", fetch_addr_upper, 32'h1231_2350);
    chk("lower step", fetch_addr_lower, 32'h1235_6790);
    wr(OFF_CTRL, 32'h0001_0031);
    wf;
    wf;
    chk("frame toggle", lines_per_toggle, 3);
    rd(OFF_RED, 32'h0, RESP_OKAY);
    rd(12'h100, 32'h0, RESP_SLVERR);
    complete_run;
  end
endmodule : lcd_video_timing_dither_config_tb_top
